// file: harvard_core_params.svh
`ifndef HARVARD_CORE_PARAMS_SVH
`define HARVARD_CORE_PARAMS_SVH

// ************************************************************
// Widths
// ************************************************************
`define INSTR_W          12
`define DATA_W           8
`define FADDR_W          7
`define PC_W             9

// ************************************************************
// Timing
// ************************************************************
`define INSTR_CYCLE_NS   200
`define REF_OSC_MHZ      20
// Oscillator periods in one instruction cycle: 200 ns * 20 MHz = 4
`define PHASES_PER_CYCLE ((`INSTR_CYCLE_NS * `REF_OSC_MHZ) / 1000)

// ************************************************************
// Special registers in data memory
// ************************************************************
`define ADDR_INDIRECT    7'h00
`define ADDR_PC_LOW      7'h02
`define ADDR_STATUS      7'h03
`define ADDR_FSEL        7'h04
`define STAT_C           0
`define STAT_DC          1
`define STAT_Z           2
`define STATUS_RESET     8'h00
`define FSEL_RESET       8'h00
`define W_RESET          8'h00
`define RESET_VECTOR     9'h000

// ************************************************************
// Instruction encoding
// ************************************************************
`define GOTO_PREFIX      3'h7
`define OP_ADD           4'h0
`define OP_SUB           4'h1
`define OP_AND           4'h2
`define OP_IOR           4'h3
`define OP_XOR           4'h4
`define OP_RLF           4'h5
`define OP_RRF           4'h6
`define OP_MOVF          4'h7
`define OP_MOVLW         4'h8
`define OP_ADDLW         4'h9
`define OP_ANDLW         4'hA
`define OP_XORLW         4'hB
`define OP_WREG          4'hC
`define NOP_WORD         12'hD00

`endif

// file: harvard_core_pkg.sv
package harvard_core_pkg;

  typedef enum logic [1:0] {ph_q1, ph_q2, ph_q3, ph_q4} phase_t;

  typedef enum logic [3:0] {
    alu_add, alu_sub, alu_and, alu_ior, alu_xor,
    alu_rlf, alu_rrf, alu_pass, alu_com, alu_passw
  } alu_op_t;

endpackage

// file: alu_if.sv
`timescale 1ns/10ps
interface alu_if;
  import harvard_core_pkg::*;
  alu_op_t    op;
  logic [7:0] a;
  logic [7:0] w;
  logic       cin;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       z;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;

  modport core (output op, a, w, cin, input res, c, dc, z, upd_c, upd_dc, upd_z);
  modport unit (input op, a, w, cin, output res, c, dc, z, upd_c, upd_dc, upd_z);
endinterface

// file: core_alu.sv
`timescale 1ns/10ps
module core_alu
(
  alu_if.unit   bus
);
  import harvard_core_pkg::*;

  function automatic logic [4:0] nib_add(input logic [3:0] x, input logic [3:0] y, input logic ci);
    nib_add = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  logic [4:0] lo;
  logic [4:0] hi;
  logic [7:0] addend;
  logic       add_cin;

  // ************************************************************
  // Adder shared by add and subtract
  // ************************************************************
  // Subtract is a + ~w + 1, so the carries come out as inverted borrows
  always_comb
  begin
    addend  = (bus.op == alu_sub) ? ~bus.w : bus.w;
    add_cin = (bus.op == alu_sub);
    lo      = nib_add(bus.a[3:0], addend[3:0], add_cin);
    hi      = nib_add(bus.a[7:4], addend[7:4], lo[4]);
  end

  always_comb
  begin
    bus.res    = 8'h00;
    bus.c      = 1'b0;
    bus.dc     = lo[4];
    bus.upd_c  = 1'b0;
    bus.upd_dc = 1'b0;
    bus.upd_z  = 1'b1;
    case (bus.op)
      alu_add, alu_sub:
      begin
        bus.res    = {hi[3:0], lo[3:0]};
        bus.c      = hi[4];
        bus.upd_c  = 1'b1;
        bus.upd_dc = 1'b1;
      end
      alu_and:   bus.res = bus.a & bus.w;
      alu_ior:   bus.res = bus.a | bus.w;
      alu_xor:   bus.res = bus.a ^ bus.w;
      alu_rlf:
      begin
        bus.res   = {bus.a[6:0], bus.cin};
        bus.c     = bus.a[7];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      alu_rrf:
      begin
        bus.res   = {bus.cin, bus.a[7:1]};
        bus.c     = bus.a[0];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      alu_pass:  bus.res = bus.a;
      alu_com:   bus.res = ~bus.w;
      alu_passw:
      begin
        bus.res   = bus.w;
        bus.upd_z = 1'b0;
      end
      default:   bus.res = 8'h00;
    endcase
    bus.z = (bus.res == 8'h00);
  end

endmodule // core_alu

// file: harvard_cpu_core_datapath.sv
`timescale 1ns/10ps
`include "harvard_core_params.svh"
// How it works
// - Each instruction is one 12-bit word held in one program-memory location.
// - A whole instruction word is taken from the program bus once per instruction cycle.
// - The next instruction is fetched while the current one executes, so plain instructions take one cycle.
// - A branch throws away the word already fetched and refetches at the target, costing two cycles.
// - Program and data use separate buses that work in the same cycle, with 8-bit data words.
// - Special registers, the low program counter among them, sit in data memory, direct or indirect.
// - The ALU is 8 bits wide and does add, subtract, shift and logic operations.
// - Arithmetic treats operands as two's complement.
// - Two-operand work takes the accumulator plus a file register or an immediate constant.
// - One-operand work acts on either the accumulator or a file register.
// - The 8-bit accumulator has no data-memory address.
// - Carry, digit carry and zero flags in the status register follow the instruction executed.
// - In subtraction carry and digit carry are inverted borrow and digit borrow.
// - The external reset pin is active low and its weak pull-up is always on.
module harvard_cpu_core_datapath
#(
  parameter int PC_W = `PC_W
)
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_ext_reset_n,
  output logic [PC_W-1:0]          o_prog_addr,
  input  wire logic [`INSTR_W-1:0] i_prog_data,
  output logic [`FADDR_W-1:0]      o_dmem_addr,
  output logic [`DATA_W-1:0]       o_dmem_wdata,
  output logic                     o_dmem_we,
  input  wire logic [`DATA_W-1:0]  i_dmem_rdata,
  output logic                     o_ext_reset_pullup_en,
  output logic [`DATA_W-1:0]       o_w_value,
  output logic [`DATA_W-1:0]       o_status
);
  import harvard_core_pkg::*;

  logic                rst;
  phase_t              phase_q;
  logic [`INSTR_W-1:0] ir_q;
  logic [PC_W-1:0]     pc_q;
  logic [PC_W-1:0]     tgt_q;
  logic                branch_q;
  logic [7:0]          w_q;
  logic [7:0]          status_q;
  logic [7:0]          fsel_q;
  logic [7:0]          opnd_q;
  logic [6:0]          ea;
  logic [7:0]          rd_mux;
  logic [3:0]          op;
  logic                is_goto;
  logic                file_op;
  logic                lit_op;
  logic                movwf;
  logic                comw;
  logic                wr_w;
  logic                wr_f;
  logic [7:0]          wr_val;

  alu_if alu ();

  core_alu u_alu
  (
    .bus (alu)
  );

  // ************************************************************
  // Reset and pin
  // ************************************************************
  // The pull-up itself is analog; this only reports that it is never switched off
  assign o_ext_reset_pullup_en = 1'b1;
  assign rst                   = i_sys_rst | ~i_ext_reset_n;

  // ************************************************************
  // Decode
  // ************************************************************
  assign op      = ir_q[11:8];
  assign is_goto = (ir_q[11:9] == `GOTO_PREFIX);
  assign file_op = !is_goto && (op <= `OP_MOVF);
  assign lit_op  = !is_goto && (op >= `OP_MOVLW) && (op <= `OP_XORLW);
  assign movwf   = (op == `OP_WREG) && !ir_q[7];
  assign comw    = (op == `OP_WREG) && ir_q[7];
  // Address zero redirects through the file select register
  assign ea      = (ir_q[6:0] == `ADDR_INDIRECT) ? fsel_q[6:0] : ir_q[6:0];
  assign wr_w    = lit_op | comw | (file_op & !ir_q[7]);
  assign wr_f    = (file_op & ir_q[7]) | movwf;
  assign wr_val  = alu.res;

  always_comb
  begin
    alu.op  = alu_pass;
    alu.a   = lit_op ? ir_q[7:0] : opnd_q;
    alu.w   = w_q;
    alu.cin = status_q[`STAT_C];
    case (op)
      `OP_ADD, `OP_ADDLW: alu.op = alu_add;
      `OP_SUB:            alu.op = alu_sub;
      `OP_AND, `OP_ANDLW: alu.op = alu_and;
      `OP_IOR:            alu.op = alu_ior;
      `OP_XOR, `OP_XORLW: alu.op = alu_xor;
      `OP_RLF:            alu.op = alu_rlf;
      `OP_RRF:            alu.op = alu_rrf;
      `OP_MOVF:           alu.op = alu_pass;
      `OP_MOVLW:          alu.op = alu_pass;
      `OP_WREG:           alu.op = ir_q[7] ? alu_com : alu_passw;
      default:            alu.op = alu_pass;
    endcase
  end

  // Special registers read from inside the core, everything else from the data bus
  always_comb
  begin
    case (ea)
      `ADDR_INDIRECT: rd_mux = 8'h00;
      `ADDR_PC_LOW:   rd_mux = pc_q[7:0];
      `ADDR_STATUS:   rd_mux = status_q;
      `ADDR_FSEL:     rd_mux = fsel_q;
      default:        rd_mux = i_dmem_rdata;
    endcase
  end

  // ************************************************************
  // Phase counter
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
      phase_q <= ph_q1;
    else
      phase_q <= phase_t'(phase_q + 2'(1));
  end

  // ************************************************************
  // Fetch and program counter
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      pc_q     <= PC_W'(`RESET_VECTOR);
      ir_q     <= `NOP_WORD;
      branch_q <= 1'b0;
      tgt_q    <= PC_W'(`RESET_VECTOR);
    end
    else
    begin
      if (phase_q == ph_q3 && is_goto)
      begin
        branch_q <= 1'b1;
        tgt_q    <= PC_W'(ir_q[8:0]);
      end
      else if (phase_q == ph_q3 && wr_f && ea == `ADDR_PC_LOW)
      begin
        branch_q <= 1'b1;
        tgt_q    <= {pc_q[PC_W-1:8], wr_val};
      end
      if (phase_q == ph_q4)
      begin
        branch_q <= 1'b0;
        if (branch_q)
        begin
          // Word fetched behind the branch is dropped; a dead cycle follows
          ir_q <= `NOP_WORD;
          pc_q <= tgt_q;
        end
        else
        begin
          ir_q <= i_prog_data;
          pc_q <= PC_W'(pc_q + PC_W'(1));
        end
      end
    end
  end

  assign o_prog_addr = pc_q;

  // ************************************************************
  // Data bus
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      o_dmem_addr  <= 7'h00;
      o_dmem_wdata <= 8'h00;
      o_dmem_we    <= 1'b0;
      opnd_q       <= 8'h00;
    end
    else
    begin
      if (phase_q == ph_q1)
        o_dmem_addr <= ea;
      if (phase_q == ph_q2)
        opnd_q <= rd_mux;
      if (phase_q == ph_q3 && wr_f && ea != `ADDR_PC_LOW && ea != `ADDR_STATUS &&
          ea != `ADDR_FSEL && ea != `ADDR_INDIRECT)
      begin
        o_dmem_wdata <= wr_val;
        o_dmem_we    <= 1'b1;
      end
      else if (phase_q == ph_q4)
        o_dmem_we <= 1'b0;
    end
  end

  // ************************************************************
  // Accumulator, select and status
  // ************************************************************
  // The accumulator is written only as an instruction result, never by address
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
      w_q <= `W_RESET;
    else if (phase_q == ph_q3 && wr_w)
      w_q <= wr_val;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
      fsel_q <= `FSEL_RESET;
    else if (phase_q == ph_q3 && wr_f && ea == `ADDR_FSEL)
      fsel_q <= wr_val;
  end

  // A direct write to status takes the stored value; flag updates are dropped then
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
      status_q <= `STATUS_RESET;
    else if (phase_q == ph_q3 && !is_goto)
    begin
      if (wr_f && ea == `ADDR_STATUS)
        status_q <= wr_val;
      else if (file_op || lit_op || comw)
      begin
        if (alu.upd_c)
          status_q[`STAT_C] <= alu.c;
        if (alu.upd_dc)
          status_q[`STAT_DC] <= alu.dc;
        if (alu.upd_z)
          status_q[`STAT_Z] <= alu.z;
      end
    end
  end

  assign o_w_value = w_q;
  assign o_status  = status_q;

endmodule // harvard_cpu_core_datapath

// file: harvard_core_props.sv
`timescale 1ns/10ps
`include "harvard_core_params.svh"
module harvard_core_props
#(
  parameter int PC_W = `PC_W
)
(
  input wire logic                i_sys_clk,
  input wire logic                i_sys_rst,
  input wire logic                i_ext_reset_n,
  input wire logic [PC_W-1:0]     o_prog_addr,
  input wire logic [`INSTR_W-1:0] i_prog_data,
  input wire logic [`FADDR_W-1:0] o_dmem_addr,
  input wire logic [`DATA_W-1:0]  o_dmem_wdata,
  input wire logic                o_dmem_we,
  input wire logic [`DATA_W-1:0]  i_dmem_rdata,
  input wire logic                o_ext_reset_pullup_en,
  input wire logic [`DATA_W-1:0]  o_w_value,
  input wire logic [`DATA_W-1:0]  o_status
);
  // ************************************************************
  // Steps of one instruction cycle
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst || !i_ext_reset_n);

  sequence s_pc_hold;
    $stable(o_prog_addr)[*3];
  endsequence
  sequence s_addr_hold;
    $stable(o_dmem_addr)[*3];
  endsequence
  sequence s_we_quiet;
    (!o_dmem_we)[*3];
  endsequence

  property p_pullup;
    o_ext_reset_pullup_en == 1'b1;
  endproperty
  property p_pc_hold;
    $changed(o_prog_addr) |=> s_pc_hold;
  endproperty
  property p_addr_hold;
    $changed(o_dmem_addr) |=> s_addr_hold;
  endproperty
  property p_we_pulse;
    $rose(o_dmem_we) |=> s_we_quiet;
  endproperty
  // Internal special registers never reach the external data memory
  property p_we_target;
    o_dmem_we |-> !(o_dmem_addr inside {7'h00, 7'h02, 7'h03, 7'h04});
  endproperty
  property p_wdata_hold;
    !o_dmem_we |=> o_dmem_we || $stable(o_dmem_wdata);
  endproperty
  property p_sys_reset;
    $fell(i_sys_rst) |-> o_prog_addr == '0 && o_w_value == 8'h00 && o_status == 8'h00 && !o_dmem_we;
  endproperty
  property p_ext_reset;
    $rose(i_ext_reset_n) |-> o_prog_addr == '0 && o_w_value == 8'h00 && o_status == 8'h00;
  endproperty

  a_pullup:    assert property (p_pullup)    else $error("reset pull-up not enabled");
  a_pc_hold:   assert property (p_pc_hold)   else $error("program address held under 4 clocks");
  a_addr_hold: assert property (p_addr_hold) else $error("data address held under 4 clocks");
  a_we_pulse:  assert property (p_we_pulse)  else $error("write strobe longer than one clock");
  a_we_target: assert property (p_we_target) else $error("write to internal register address");
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved without a write");
  a_sys_reset: assert property (p_sys_reset) else $error("state not cleared by system reset");
  a_ext_reset: assert property (p_ext_reset) else $error("state not cleared by reset pin");
endmodule // harvard_core_props

bind harvard_cpu_core_datapath harvard_core_props #(.PC_W(PC_W)) u_props (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_ext_reset_n(i_ext_reset_n), .o_prog_addr(o_prog_addr), .i_prog_data(i_prog_data),
  .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata), .o_dmem_we(o_dmem_we), .i_dmem_rdata(i_dmem_rdata),
  .o_ext_reset_pullup_en(o_ext_reset_pullup_en), .o_w_value(o_w_value), .o_status(o_status));

// file: harvard_mem_model.sv
`timescale 1ns/10ps
module harvard_mem_model
(
  input  wire logic        i_clk,
  input  wire logic [8:0]  i_prog_addr,
  output logic      [11:0] o_prog_data,
  input  wire logic [6:0]  i_dmem_addr,
  input  wire logic [7:0]  i_dmem_wdata,
  input  wire logic        i_dmem_we,
  output logic      [7:0]  o_dmem_rdata
);
  logic [11:0] prog [512];
  logic [7:0]  dmem [128];
  // Two separate ports, so a fetch and a data access share a cycle
  assign o_prog_data  = prog[i_prog_addr];
  assign o_dmem_rdata = dmem[i_dmem_addr];
  always @(posedge i_clk)
  begin
    if (i_dmem_we)
      dmem[i_dmem_addr] <= i_dmem_wdata;
  end
endmodule // harvard_mem_model

// file: harvard_cpu_core_datapath_tb_top.sv
`timescale 1ns/10ps
`include "harvard_core_params.svh"
module harvard_cpu_core_datapath_tb_top;
  logic        i_sys_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_ext_reset_n = 1'b1;
  logic [8:0]  pa;
  logic [11:0] pd;
  logic [6:0]  da;
  logic [7:0]  wd, rd, wv, st;
  logic        we, pu;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          ecnt = 0;
  logic [11:0] code [12] = '{12'h80F, 12'h901, 12'hC10, 12'h805, 12'h110, 12'hB0B,
                             12'hE09, 12'h8AA, 12'h8BB, 12'h83C, 12'h9C4, 12'hE0B};
  // Second program: select register, indirect access, rotate, complement, status and pc low writes
  logic [11:0] code2 [11] = '{12'h844, 12'hC04, 12'h8A5, 12'hC00, 12'h800, 12'h700,
                              12'h500, 12'hC80, 12'hC03, 12'hC02, 12'h877};

  harvard_cpu_core_datapath uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_ext_reset_n(i_ext_reset_n),
    .o_prog_addr(pa), .i_prog_data(pd), .o_dmem_addr(da), .o_dmem_wdata(wd), .o_dmem_we(we),
    .i_dmem_rdata(rd), .o_ext_reset_pullup_en(pu), .o_w_value(wv), .o_status(st));
  harvard_mem_model u_mem (.i_clk(i_sys_clk), .i_prog_addr(pa), .o_prog_data(pd), .i_dmem_addr(da),
    .i_dmem_wdata(wd), .i_dmem_we(we), .o_dmem_rdata(rd));

  initial forever #10 i_sys_clk = ~i_sys_clk;
  // Edges since the last reset release: the timing reference of all checks made with reset released
  always @(posedge i_sys_clk) ecnt <= (i_sys_rst || !i_ext_reset_n) ? 0 : ecnt + 1;

  // ************************************************************
  // Helpers
  // ************************************************************
  task check(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wait_to(input int k);
    while (ecnt != k)
    begin
      @(posedge i_sys_clk);
      #1;
    end
  endtask
  task finish_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset_values;
    check(pu, 12'h001);
    check(wv, 12'h000);
    check(st, 12'h000);
    check(pa, 12'h000);
  endtask
  task t_fetch;
    wait_to(3);
    check(pa, 12'h000);
    wait_to(4);
    check(pa, 12'h001);
  endtask
  task t_arith;
    wait_to(8);
    check(wv, 8'h0F);
    wait_to(12);
    check(wv, 8'h10);
    check(st, 8'h02);
    wait_to(16);
    check(u_mem.dmem[7'h10], 8'h10);
    wait_to(24);
    check(wv, 8'h0B);
    check(st, 8'h01);
    wait_to(28);
    check(wv, 8'h00);
    check(st, 8'h05);
  endtask
  task t_branch;
    wait_to(32);
    check(pa, 12'h009);
    wait_to(36);
    check(wv, 8'h00);
    wait_to(40);
    check(wv, 8'h3C);
    wait_to(44);
    check(wv, 8'h00);
    check(st, 8'h07);
  endtask
  task t_ext_reset;
    @(posedge i_sys_clk);
    #1 i_ext_reset_n = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(wv, 12'h000);
    check(st, 12'h000);
    check(pa, 12'h000);
    i_ext_reset_n = 1'b1;
    wait_to(8);
    check(wv, 8'h0F);
  endtask
  // Mid-run system reset, then a program that only reaches its data through special registers
  task t_special;
    @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b1;
    for (int i = 0; i < 11; i++) u_mem.prog[i] = code2[i];
    u_mem.prog[9'h0B5] = 12'h866;
    repeat (2) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b0;
    wait_to(8);
    check(wv, 8'h44);
    wait_to(20);
    check(u_mem.dmem[7'h44], 8'hA5);
    wait_to(24);
    check(st, 8'h04);
    wait_to(28);
    check(wv, 8'hA5);
    check(st, 8'h00);
    wait_to(32);
    check(wv, 8'h4A);
    check(st, 8'h01);
    wait_to(36);
    check(wv, 8'hB5);
    wait_to(40);
    check(st, 8'hB5);
    wait_to(44);
    check(pa, 12'h0B5);
    wait_to(48);
    check(wv, 8'hB5);
    wait_to(52);
    check(wv, 8'h66);
    check(st, 8'hB1);
  endtask

  initial
  begin
    for (int i = 0; i < 512; i++) u_mem.prog[i] = `NOP_WORD;
    for (int i = 0; i < 128; i++) u_mem.dmem[i] = 8'h00;
    for (int i = 0; i < 12; i++) u_mem.prog[i] = code[i];
    repeat (8) @(posedge i_sys_clk);
    #1;
    t_reset_values();
    i_sys_rst = 1'b0;
    t_fetch();
    t_arith();
    t_branch();
    t_ext_reset();
    t_special();
    finish_test();
  end

  // Whole run is under 200 cycles; 5000 leaves ample margin
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule // harvard_cpu_core_datapath_tb_top
